// >>> hdl/rgc_map.svh
// Register offsets, field positions, codes and reset values of the global config bank
`ifndef RGC_MAP_SVH
`define RGC_MAP_SVH
// Register offsets
`define RGC_OFS_SLEW 8'h0c
`define RGC_OFS_CTRL 8'h0d
`define RGC_OFS_EQ 8'h0e
`define RGC_OFS_LANE 8'h11
// Reset values
`define RGC_RST_SLEW 8'h71
`define RGC_RST_CTRL 8'h22
`define RGC_RST_EQ 8'h3f
`define RGC_RST_LANE 8'h5f
// Writable bit masks; zero bits are reserved
`define RGC_MASK_SLEW 8'h77
`define RGC_MASK_CTRL 8'hff
`define RGC_MASK_EQ 8'hff
`define RGC_MASK_LANE 8'hff
`define RGC_RD_ZERO 8'h00
// Slew register fields
`define RGC_HRSLEW_HI 6
`define RGC_HRSLEW_LO 4
`define RGC_CKSLEW_HI 2
`define RGC_CKSLEW_LO 0
// Control register fields
`define RGC_LINEAR_BIT 7
`define RGC_ACCOUPLE_BIT 6
`define RGC_DCG_HI 5
`define RGC_DCG_LO 4
`define RGC_AUTOTERM_BIT 3
`define RGC_BYPASS_BIT 2
`define RGC_TERM_HI 1
`define RGC_TERM_LO 0
// Equalizer register fields
`define RGC_BW_HI 7
`define RGC_BW_LO 6
`define RGC_EQ14_HI 5
`define RGC_EQ14_LO 4
`define RGC_EQ20_HI 3
`define RGC_EQ20_LO 2
`define RGC_EQ21_HI 1
`define RGC_EQ21_LO 0
// Lane enable register fields
`define RGC_SW20_HI 7
`define RGC_SW20_LO 6
`define RGC_SW14_HI 5
`define RGC_SW14_LO 4
`define RGC_LANEEN_HI 3
`define RGC_LANEEN_LO 0
// Two-bit codes shared by several fields
`define RGC_CODE0 2'h0
`define RGC_CODE1 2'h1
`define RGC_CODE2 2'h2
`define RGC_CODE3 2'h3
`endif

// >>> hdl/rgc_pkg.sv
// Types of the global config register bank
package rgc_pkg;
  // Active link mode
  typedef enum logic [1:0] {RGC_LEGACY14, RGC_MODE20, RGC_FRL21} rgc_mode_t;
  // Snooped or programmed link rate
  typedef enum logic [2:0] {RGC_R3G, RGC_R6G, RGC_R8G, RGC_R10G, RGC_R12G} rgc_rate_t;
  // Equalizer variant chosen per lane
  typedef enum logic [1:0] {RGC_CTLE_3G, RGC_CTLE_6G, RGC_CTLE_12G} rgc_ctle_t;
  // TX termination outcome
  typedef enum logic [1:0] {RGC_TERM_NONE, RGC_TERM_300, RGC_TERM_100} rgc_term_t;
  // Limited-mode swing source
  typedef enum logic [2:0] {RGC_SW_PER_LANE, RGC_SW_NOMINAL, RGC_SW_MINUS5, RGC_SW_PLUS5,
    RGC_SW_MINUS10} rgc_swing_t;
endpackage

// >>> hdl/rgc_if.sv
// Carrier between the register bank and its field decoder
interface rgc_if;
  logic [7:0] slew;
  logic [7:0] ctrl;
  logic [7:0] eq;
  logic [7:0] lane;
  rgc_pkg::rgc_mode_t mode;
  rgc_pkg::rgc_rate_t rate;
  logic legacy_auto_300;
  logic [3:0] lane_eq_zero;
  logic [2:0] data_slew;
  logic [2:0] clock_slew;
  rgc_pkg::rgc_term_t term;
  logic term50;
  rgc_pkg::rgc_ctle_t [3:0] ctle;
  logic [3:0] bypass;
  rgc_pkg::rgc_swing_t swing;
  modport regs (output slew, ctrl, eq, lane, mode, rate, legacy_auto_300, lane_eq_zero,
    input data_slew, clock_slew, term, term50, ctle, bypass, swing);
  modport dec (input slew, ctrl, eq, lane, mode, rate, legacy_auto_300, lane_eq_zero,
    output data_slew, clock_slew, term, term50, ctle, bypass, swing);
endinterface

// >>> hdl/rgc_decode.sv
// Combinational decode of register fields into lane analog controls
`include "rgc_map.svh"
module rgc_decode (
  rgc_if.dec c
);
  logic [1:0] eq14;
  logic [1:0] eq20;
  logic [1:0] eq21;
  logic [1:0] term_code;
  logic frl_high;
  rgc_pkg::rgc_ctle_t auto_ctle;
  rgc_pkg::rgc_ctle_t data_ctle;
  rgc_pkg::rgc_ctle_t clk_ctle;

  assign eq14 = c.eq[`RGC_EQ14_HI:`RGC_EQ14_LO];
  assign eq20 = c.eq[`RGC_EQ20_HI:`RGC_EQ20_LO];
  assign eq21 = c.eq[`RGC_EQ21_HI:`RGC_EQ21_LO];
  assign term_code = c.ctrl[`RGC_TERM_HI:`RGC_TERM_LO];
  assign frl_high = (c.mode == rgc_pkg::RGC_FRL21) && (c.rate inside
    {rgc_pkg::RGC_R8G, rgc_pkg::RGC_R10G, rgc_pkg::RGC_R12G});

  // Slew: high-rate field only for fast links, clock field only before link mode 2.1
  assign c.data_slew = frl_high ? c.slew[`RGC_HRSLEW_HI:`RGC_HRSLEW_LO] : 3'h0;
  assign c.clock_slew = (c.mode != rgc_pkg::RGC_FRL21) ?
    c.slew[`RGC_CKSLEW_HI:`RGC_CKSLEW_LO] : c.data_slew;

  // Auto equalizer choice follows the rate, whether snooped or host written
  always_comb
  begin
    unique case (c.rate)
      rgc_pkg::RGC_R3G: auto_ctle = rgc_pkg::RGC_CTLE_3G;
      rgc_pkg::RGC_R6G: auto_ctle = rgc_pkg::RGC_CTLE_6G;
      default: auto_ctle = rgc_pkg::RGC_CTLE_12G;
    endcase
  end

  // Data lane equalizer per active mode
  always_comb
  begin
    logic [1:0] code;
    code = eq14;
    unique case (c.mode)
      rgc_pkg::RGC_LEGACY14: code = eq14;
      rgc_pkg::RGC_MODE20: code = eq20;
      rgc_pkg::RGC_FRL21: code = eq21;
      default: code = eq14;
    endcase
    unique case (code)
      `RGC_CODE0: data_ctle = rgc_pkg::RGC_CTLE_3G;
      `RGC_CODE1: data_ctle = rgc_pkg::RGC_CTLE_6G;
      `RGC_CODE2: data_ctle = auto_ctle;
      default: data_ctle = rgc_pkg::RGC_CTLE_12G;
    endcase
  end

  // Clock lane stays on the slowest equalizer except in the four-lane mode
  assign clk_ctle = (c.mode == rgc_pkg::RGC_FRL21) ? data_ctle : rgc_pkg::RGC_CTLE_3G;

  // Per lane equalizer and bypass; index 3 is the clock lane
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    assign c.ctle[i] = (i == 3) ? clk_ctle : data_ctle;
    assign c.bypass[i] = c.ctrl[`RGC_BYPASS_BIT] &&
      (c.ctrl[`RGC_DCG_HI:`RGC_DCG_LO] == `RGC_CODE2) && c.lane_eq_zero[i];
  end

  // Termination, with the auto code resolved by mode
  always_comb
  begin
    unique case (term_code)
      `RGC_CODE0: c.term = rgc_pkg::RGC_TERM_NONE;
      `RGC_CODE1: c.term = rgc_pkg::RGC_TERM_300;
      `RGC_CODE3: c.term = rgc_pkg::RGC_TERM_100;
      default:
        if (c.mode == rgc_pkg::RGC_LEGACY14)
          c.term = c.legacy_auto_300 ? rgc_pkg::RGC_TERM_300 : rgc_pkg::RGC_TERM_NONE;
        else if (c.mode == rgc_pkg::RGC_MODE20)
          c.term = rgc_pkg::RGC_TERM_300;
        else
          c.term = rgc_pkg::RGC_TERM_100;
    endcase
  end
  assign c.term50 = c.ctrl[`RGC_ACCOUPLE_BIT];

  // Swing preset; linear mode and the four-lane mode use per-lane fields
  always_comb
  begin
    logic [1:0] sw;
    sw = c.lane[`RGC_SW14_HI:`RGC_SW14_LO];
    if (c.mode == rgc_pkg::RGC_MODE20)
      sw = c.lane[`RGC_SW20_HI:`RGC_SW20_LO];
    unique case (sw)
      `RGC_CODE0: c.swing = rgc_pkg::RGC_SW_PER_LANE;
      `RGC_CODE1: c.swing = rgc_pkg::RGC_SW_NOMINAL;
      `RGC_CODE2: c.swing = rgc_pkg::RGC_SW_MINUS5;
      default: c.swing = (c.mode == rgc_pkg::RGC_MODE20) ?
        rgc_pkg::RGC_SW_PLUS5 : rgc_pkg::RGC_SW_MINUS10;
    endcase
    if (c.ctrl[`RGC_LINEAR_BIT] || c.mode == rgc_pkg::RGC_FRL21)
      c.swing = rgc_pkg::RGC_SW_PER_LANE;
  end
endmodule

// >>> hdl/rgc_regs.sv
// Global configuration register bank with decoded lane controls
//
// What this block does
// - Offset 0x0C bits 6-4 set data slew at 8/10/12 Gbps in 2.1 mode, reset 7h.
// - Offset 0x0C bits 2-0 set clock slew in legacy and 2.0 modes, reset 1h.
// - Offset 0x0D bit 7 chooses limited (0) or linear (1) redriving, reset 0.
// - Offset 0x0D bit 6 chooses DC or AC coupling; AC adds 50 ohm pull-ups.
// - Offset 0x0D bits 5-4 set equalizer DC gain, reset 2h.
// - Offset 0x0D bits 1-0 pick termination: none, 300, auto, 100; reset 2h.
// - Legacy auto termination: bit 3 clear follows clock rate, set forces 300 ohm.
// - Equalizer bypassed only with bypass bit, gain code 2h and lane EQ zero.
// - Offset 0x0E bits 7-6 set equalizer bandwidth, reset 0h.
// - Offset 0x0E bits 5-4 pick legacy data equalizer; clock lane fixed at 3G.
// - Offset 0x0E bits 3-2 pick 2.0 data equalizer; clock lane fixed at 3G.
// - Offset 0x0E bits 1-0 pick equalizer of all lanes in 2.1 mode.
// - Offset 0x11 bits 7-6 pick limited swing preset in 2.0 mode.
// - Offset 0x11 bits 5-4 pick limited swing preset in legacy mode.
// - Offset 0x11 bits 3-0 enable clock lane and data lanes 0-2, reset on.
// - Without snooping the host supplies the rate used by auto equalizer selection.
`include "rgc_map.svh"
module rgc_regs #(
  parameter int NUM_LANES = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Management register port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Link state from detection or host programming
  input wire rgc_pkg::rgc_mode_t link_mode_i,
  input wire rgc_pkg::rgc_rate_t link_rate_i,
  input wire logic legacy_clk_le_165_i,
  input wire logic legacy_clk_gt_225_i,
  input wire logic [3:0] lane_eq_zero_i,
  // Lane analog controls
  output logic [2:0] data_slew_o,
  output logic [2:0] clock_slew_o,
  output logic linear_mode_o,
  output logic tx_term50_o,
  output rgc_pkg::rgc_term_t tx_term_o,
  output logic [1:0] eq_dc_gain_o,
  output logic [1:0] eq_bandwidth_o,
  output rgc_pkg::rgc_ctle_t [3:0] lane_ctle_o,
  output logic [3:0] lane_bypass_o,
  output rgc_pkg::rgc_swing_t swing_preset_o,
  output logic [3:0] lane_enable_o
);

  // The lane enable field has exactly one bit per lane
  if (NUM_LANES != 4)
  begin : g_bad_lanes
    $error("rgc_regs supports exactly four lanes");
  end

  logic [7:0] slew_ctrl_high_rate_q;
  logic [7:0] global_ctrl_term_gain_q;
  logic [7:0] global_equalizer_ctrl_q;
  logic [7:0] lane_enable_swing_q;
  logic legacy_auto_300_q;
  logic legacy_auto_300_d;
  logic [7:0] rdata_d;

  rgc_if c ();

  // Slew register; reserved bits 7 and 3 never store
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      slew_ctrl_high_rate_q <= `RGC_RST_SLEW;
    else if (wr_en_i && addr_i == `RGC_OFS_SLEW)
      slew_ctrl_high_rate_q <= wdata_i & `RGC_MASK_SLEW;
  end

  // Coupling, gain, termination and bypass register
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      global_ctrl_term_gain_q <= `RGC_RST_CTRL;
    else if (wr_en_i && addr_i == `RGC_OFS_CTRL)
      global_ctrl_term_gain_q <= wdata_i & `RGC_MASK_CTRL;
  end

  // Equalizer bandwidth and per-mode selection register
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      global_equalizer_ctrl_q <= `RGC_RST_EQ;
    else if (wr_en_i && addr_i == `RGC_OFS_EQ)
      global_equalizer_ctrl_q <= wdata_i & `RGC_MASK_EQ;
  end

  // Swing presets and lane enables register
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lane_enable_swing_q <= `RGC_RST_LANE;
    else if (wr_en_i && addr_i == `RGC_OFS_LANE)
      lane_enable_swing_q <= wdata_i & `RGC_MASK_LANE;
  end

  // Legacy auto termination state; between 165 and 225 MHz the last choice holds,
  // which keeps the termination from chattering around a single threshold
  always_comb
  begin
    legacy_auto_300_d = legacy_auto_300_q;
    if (global_ctrl_term_gain_q[`RGC_AUTOTERM_BIT])
      legacy_auto_300_d = 1'b1;
    else if (legacy_clk_le_165_i)
      legacy_auto_300_d = 1'b0;
    else if (legacy_clk_gt_225_i)
      legacy_auto_300_d = 1'b1;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      legacy_auto_300_q <= 1'b0;
    else
      legacy_auto_300_q <= legacy_auto_300_d;
  end

  // Feed the decoder
  assign c.slew = slew_ctrl_high_rate_q;
  assign c.ctrl = global_ctrl_term_gain_q;
  assign c.eq = global_equalizer_ctrl_q;
  assign c.lane = lane_enable_swing_q;
  assign c.mode = link_mode_i;
  assign c.rate = link_rate_i;
  assign c.legacy_auto_300 = legacy_auto_300_d;
  assign c.lane_eq_zero = lane_eq_zero_i;

  rgc_decode u_decode (
    .c (c)
  );

  // Read mux; unmapped offsets answer zero
  always_comb
  begin
    unique case (addr_i)
      `RGC_OFS_SLEW: rdata_d = slew_ctrl_high_rate_q;
      `RGC_OFS_CTRL: rdata_d = global_ctrl_term_gain_q;
      `RGC_OFS_EQ: rdata_d = global_equalizer_ctrl_q;
      `RGC_OFS_LANE: rdata_d = lane_enable_swing_q;
      default: rdata_d = `RGC_RD_ZERO;
    endcase
  end

  // Read data is captured once per read and then held
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= `RGC_RD_ZERO;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_en_i;
      if (rd_en_i)
        rdata_o <= rdata_d;
    end
  end

  // Slew outputs follow the active mode and rate
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_slew_o <= 3'h0;
      clock_slew_o <= 3'h0;
    end
    else
    begin
      data_slew_o <= c.data_slew;
      clock_slew_o <= c.clock_slew;
    end
  end

  // Redriver type, coupling and termination
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      linear_mode_o <= 1'b0;
      tx_term50_o <= 1'b0;
      tx_term_o <= rgc_pkg::RGC_TERM_NONE;
    end
    else
    begin
      linear_mode_o <= global_ctrl_term_gain_q[`RGC_LINEAR_BIT];
      tx_term50_o <= c.term50;
      tx_term_o <= c.term;
    end
  end

  // Equalizer gain, bandwidth, per-lane variant and bypass
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      eq_dc_gain_o <= `RGC_CODE2;
      eq_bandwidth_o <= `RGC_CODE0;
      lane_ctle_o <= {4{rgc_pkg::RGC_CTLE_3G}};
      lane_bypass_o <= 4'h0;
    end
    else
    begin
      eq_dc_gain_o <= global_ctrl_term_gain_q[`RGC_DCG_HI:`RGC_DCG_LO];
      eq_bandwidth_o <= global_equalizer_ctrl_q[`RGC_BW_HI:`RGC_BW_LO];
      lane_ctle_o <= c.ctle;
      lane_bypass_o <= c.bypass;
    end
  end

  // Swing preset and lane enables
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      swing_preset_o <= rgc_pkg::RGC_SW_PER_LANE;
      lane_enable_o <= 4'h0;
    end
    else
    begin
      swing_preset_o <= c.swing;
      lane_enable_o <= lane_enable_swing_q[`RGC_LANEEN_HI:`RGC_LANEEN_LO];
    end
  end

endmodule

// >>> verif/rgc_regs_assertions.sv
// Port checker of the global config register bank
module rgc_regs_assertions (
  // Clock, reset and register port
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  // Link state and lane controls
  input wire rgc_pkg::rgc_mode_t link_mode_i,
  input wire logic [3:0] lane_eq_zero_i,
  input wire logic [2:0] data_slew_o,
  input wire logic linear_mode_o,
  input wire logic [1:0] eq_dc_gain_o,
  input wire rgc_pkg::rgc_ctle_t [3:0] lane_ctle_o,
  input wire logic [3:0] lane_bypass_o,
  input wire logic [3:0] lane_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Unmapped offsets answer with zero, still with a valid pulse
  property p_unmapped;
    rd_en_i && !(addr_i inside {8'h0c, 8'h0d, 8'h0e, 8'h11}) |=> rvalid_o && rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_slew_rsv;
    rd_en_i && addr_i == 8'h0c |=> (rdata_o & 8'h88) == 8'h00;
  endproperty
  a_slew_rsv: assert property (p_slew_rsv) else $error("reserved slew bits set");
  // Written fields reach the lanes two edges after the write
  property p_linear;
    wr_en_i && addr_i == 8'h0d |-> ##2 linear_mode_o == $past(wdata_i[7], 2);
  endproperty
  a_linear: assert property (p_linear) else $error("linear select wrong");
  property p_gain;
    wr_en_i && addr_i == 8'h0d |-> ##2 eq_dc_gain_o == $past(wdata_i[5:4], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("dc gain wrong");
  property p_lane_en;
    wr_en_i && addr_i == 8'h11 |-> ##2 lane_enable_o == $past(wdata_i[3:0], 2);
  endproperty
  a_lane_en: assert property (p_lane_en) else $error("lane enable wrong");
  // Bypass needs gain code 2h and a zero lane EQ
  property p_bypass;
    |lane_bypass_o |-> eq_dc_gain_o == 2'h2 && (lane_bypass_o & ~$past(lane_eq_zero_i)) == 4'h0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass without cause");
  property p_clk_ctle;
    link_mode_i != rgc_pkg::RGC_FRL21 |=> lane_ctle_o[3] == rgc_pkg::RGC_CTLE_3G;
  endproperty
  a_clk_ctle: assert property (p_clk_ctle) else $error("clock lane ctle wrong");
  property p_slew_mode;
    data_slew_o != 3'h0 |-> $past(link_mode_i) == rgc_pkg::RGC_FRL21;
  endproperty
  a_slew_mode: assert property (p_slew_mode) else $error("high rate slew outside frl");
  cover property (wr_en_i && addr_i == 8'h0d);
  cover property (|lane_bypass_o);
  cover property (rd_en_i && addr_i == 8'h0f);
endmodule

bind rgc_regs rgc_regs_assertions chk_u (.clock_i, .reset_n_i, .wr_en_i, .rd_en_i, .addr_i,
  .wdata_i, .rdata_o, .rvalid_o, .link_mode_i, .lane_eq_zero_i, .data_slew_o, .linear_mode_o,
  .eq_dc_gain_o, .lane_ctle_o, .lane_bypass_o, .lane_enable_o);

// >>> verif/rgc_link_model.sv
// Link detection side: presents mode, rate and clock flags to the bank
module rgc_link_model (
  // Clock and requested link state
  input wire logic clock_i,
  input wire rgc_pkg::rgc_mode_t mode_i,
  input wire rgc_pkg::rgc_rate_t rate_i,
  input wire logic le165_i,
  input wire logic gt225_i,
  input wire logic [3:0] eqz_i,
  // Link state seen by the bank
  output rgc_pkg::rgc_mode_t mode_o,
  output rgc_pkg::rgc_rate_t rate_o,
  output logic le165_o,
  output logic gt225_o,
  output logic [3:0] eqz_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Changes land just after an edge, as detection logic would launch them
  always @(posedge clock_i)
  begin
    #1;
    mode_o <= mode_i;
    rate_o <= rate_i; // Host-held rate when snooping is off
    le165_o <= le165_i;
    gt225_o <= gt225_i;
    eqz_o <= eqz_i;
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench of the global config register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic rvalid_o;
  rgc_pkg::rgc_mode_t mode_req = rgc_pkg::RGC_LEGACY14, link_mode;
  rgc_pkg::rgc_rate_t rate_req = rgc_pkg::RGC_R6G, link_rate;
  logic le165_req = 1'b1, gt225_req = 1'b0, le165, gt225;
  logic [3:0] eqz_req = 4'h0, eqz;
  logic [2:0] data_slew, clock_slew;
  logic linear, term50;
  rgc_pkg::rgc_term_t term;
  logic [1:0] dcg, bw, c;
  rgc_pkg::rgc_ctle_t [3:0] ctle;
  logic [3:0] bypass, lane_en;
  rgc_pkg::rgc_swing_t swing;
  int fails = 0;
  int n_checks = 0;
  int i;
  rgc_pkg::rgc_term_t term_exp[4] = '{rgc_pkg::RGC_TERM_NONE, rgc_pkg::RGC_TERM_300,
    rgc_pkg::RGC_TERM_300, rgc_pkg::RGC_TERM_100};
  rgc_pkg::rgc_swing_t sw20[4] = '{rgc_pkg::RGC_SW_PER_LANE, rgc_pkg::RGC_SW_NOMINAL,
    rgc_pkg::RGC_SW_MINUS5, rgc_pkg::RGC_SW_PLUS5};
  rgc_pkg::rgc_swing_t sw14[4] = '{rgc_pkg::RGC_SW_PER_LANE, rgc_pkg::RGC_SW_NOMINAL,
    rgc_pkg::RGC_SW_MINUS5, rgc_pkg::RGC_SW_MINUS10};
  rgc_link_model link_u (.clock_i(clock_i), .mode_i(mode_req), .rate_i(rate_req),
    .le165_i(le165_req), .gt225_i(gt225_req), .eqz_i(eqz_req), .mode_o(link_mode),
    .rate_o(link_rate), .le165_o(le165), .gt225_o(gt225), .eqz_o(eqz));
  rgc_regs dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .link_mode_i(link_mode), .link_rate_i(link_rate),
    .legacy_clk_le_165_i(le165), .legacy_clk_gt_225_i(gt225), .lane_eq_zero_i(eqz),
    .data_slew_o(data_slew), .clock_slew_o(clock_slew), .linear_mode_o(linear),
    .tx_term50_o(term50), .tx_term_o(term), .eq_dc_gain_o(dcg), .eq_bandwidth_o(bw),
    .lane_ctle_o(ctle), .lane_bypass_o(bypass), .swing_preset_o(swing),
    .lane_enable_o(lane_en));
  // Free-running 250 MHz clock
  initial
  begin
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Strobe drops just after the edge that takes it, then one idle edge follows, so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(posedge clock_i);
    #1;
    wr_en_i = 1'b0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_en_i = 1'b1;
    addr_i = a;
    @(posedge clock_i);
    #1;
    rd_en_i = 1'b0;
    chk("rvalid", rvalid_o, 8'h01);
    chk("rdata", rdata_o, exp);
    @(posedge clock_i);
    #1;
  endtask
  // Link changes pass the model and the bank: two edges, one spare
  task automatic settle;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  task automatic link(input rgc_pkg::rgc_mode_t m, input rgc_pkg::rgc_rate_t r);
    mode_req = m;
    rate_req = r;
    settle;
  endtask
  task automatic leg(input logic le, input logic gt, input rgc_pkg::rgc_term_t e);
    le165_req = le;
    gt225_req = gt;
    settle;
    chk("term", term, e);
  endtask
  function automatic rgc_pkg::rgc_ctle_t ctle_of(input logic [1:0] k, input rgc_pkg::rgc_rate_t r);
    if (k == 2'h0 || (k == 2'h2 && r == rgc_pkg::RGC_R3G))
      return rgc_pkg::RGC_CTLE_3G;
    if (k == 2'h1 || (k == 2'h2 && r == rgc_pkg::RGC_R6G))
      return rgc_pkg::RGC_CTLE_6G;
    return rgc_pkg::RGC_CTLE_12G;
  endfunction
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    rd(8'h0c, 8'h71);
    rd(8'h0d, 8'h22);
    rd(8'h0e, 8'h3f);
    rd(8'h11, 8'h5f);
    rd(8'h0f, 8'h00);
    chk("lane_en", lane_en, 8'h0f);
    $display("test reset done");
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h77);
    wr(8'h0c, 8'h25);
    link(rgc_pkg::RGC_FRL21, rgc_pkg::RGC_R12G);
    chk("data_slew", data_slew, 8'h02);
    chk("clock_slew", clock_slew, 8'h02);
    link(rgc_pkg::RGC_MODE20, rgc_pkg::RGC_R12G);
    chk("data_slew", data_slew, 8'h00);
    chk("clock_slew", clock_slew, 8'h05);
    $display("test slew done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h0d, 8'hc0 | 8'(i));
      chk("term", term, term_exp[i]);
    end
    chk("linear", linear, 8'h01);
    chk("term50", term50, 8'h01);
    chk("dcg", dcg, 8'h00);
    wr(8'h0d, 8'h22);
    link(rgc_pkg::RGC_FRL21, rgc_pkg::RGC_R12G);
    chk("term", term, rgc_pkg::RGC_TERM_100);
    link(rgc_pkg::RGC_LEGACY14, rgc_pkg::RGC_R6G);
    leg(1'b1, 1'b0, rgc_pkg::RGC_TERM_NONE);
    leg(1'b0, 1'b1, rgc_pkg::RGC_TERM_300);
    leg(1'b0, 1'b0, rgc_pkg::RGC_TERM_300);
    leg(1'b1, 1'b0, rgc_pkg::RGC_TERM_NONE);
    wr(8'h0d, 8'h2a);
    leg(1'b1, 1'b0, rgc_pkg::RGC_TERM_300);
    $display("test termination done");
    eqz_req = 4'ha;
    wr(8'h0d, 8'h26);
    settle;
    chk("bypass", bypass, 8'h0a);
    wr(8'h0d, 8'h36);
    chk("bypass", bypass, 8'h00);
    wr(8'h0d, 8'h22);
    chk("bypass", bypass, 8'h00);
    $display("test bypass done");
    for (i = 0; i < 4; i++)
    begin
      c = 2'(i);
      wr(8'h0e, {c, c, c + 2'h1, c + 2'h2});
      chk("bw", bw, c);
      link(rgc_pkg::RGC_LEGACY14, rgc_pkg::RGC_R6G);
      chk("ctle", ctle, {rgc_pkg::RGC_CTLE_3G, {3{ctle_of(c, rgc_pkg::RGC_R6G)}}});
      link(rgc_pkg::RGC_MODE20, rgc_pkg::RGC_R3G);
      chk("ctle", ctle, {rgc_pkg::RGC_CTLE_3G, {3{ctle_of(c + 2'h1, rgc_pkg::RGC_R3G)}}});
      link(rgc_pkg::RGC_FRL21, rgc_pkg::RGC_R10G);
      chk("ctle", ctle, {4{ctle_of(c + 2'h2, rgc_pkg::RGC_R10G)}});
    end
    $display("test equalizer done");
    for (i = 0; i < 4; i++)
    begin
      c = 2'(i);
      wr(8'h11, {c, c + 2'h1, ~c, c});
      chk("lane_en", lane_en, {~c, c});
      link(rgc_pkg::RGC_MODE20, rgc_pkg::RGC_R6G);
      chk("swing", swing, sw20[c]);
      link(rgc_pkg::RGC_LEGACY14, rgc_pkg::RGC_R3G);
      chk("swing", swing, sw14[c + 2'h1]);
    end
    link(rgc_pkg::RGC_FRL21, rgc_pkg::RGC_R8G);
    chk("swing", swing, rgc_pkg::RGC_SW_PER_LANE);
    $display("test swing done");
    reset_n_i = 1'b0;
    @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    rd(8'h11, 8'h5f);
    rd(8'h0d, 8'h22);
    $display("test second reset done");
    report_and_stop;
  end
  // Run needs about 150 cycles; cut a hang well beyond that
  initial
  begin
    #80000;
    fails++;
    report_and_stop;
  end
endmodule
